// File: rtl/bru_pkg.sv
// Shared constants and types of the branch unit: instruction field
// positions, opcodes, branch-options bit meanings, register offsets.
// Assumes 32-bit instructions with bit 31 of the vector as the first
// (most significant) instruction bit.
package bru_pkg;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int         OPC_MSB       = 31;
  localparam int         OPC_LSB       = 26;
  localparam int         XO_MSB        = 10;
  localparam int         XO_LSB        = 1;
  localparam int         OPTS_MSB      = 25;
  localparam int         OPTS_LSB      = 21;
  localparam int         CBIT_MSB      = 20;
  localparam int         CBIT_LSB      = 16;
  localparam int         UDISP_MSB     = 25;
  localparam int         UDISP_LSB     = 2;
  localparam int         CDISP_MSB     = 15;
  localparam int         CDISP_LSB     = 2;
  localparam int         ABS_SEL_POS   = 1;  // Instruction bit 30
  localparam int         LINK_EN_POS   = 0;  // Instruction bit 31

  localparam logic [5:0] OPC_UNCOND    = 6'h12;
  localparam logic [5:0] OPC_COND      = 6'h10;
  localparam logic [5:0] OPC_EXT       = 6'h13;
  localparam logic [9:0] XO_TO_LINK    = 10'h010;
  localparam logic [9:0] XO_TO_COUNT   = 10'h210;

  // ----------------------------------------------------------------
  // Branch-options field, vector bit 4 is the first field bit
  // ----------------------------------------------------------------
  localparam int         OPT_CR_SKIP   = 4;
  localparam int         OPT_CR_VALUE  = 3;
  localparam int         OPT_CNT_SKIP  = 2;
  localparam int         OPT_CNT_ZERO  = 1;
  localparam int         OPT_HINT      = 0;
  localparam logic [4:0] OPTS_ALWAYS   = 5'h14;

  localparam logic [31:0] INSTR_STEP   = 32'h0000_0004;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int         REG_AW        = 4;
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_LINK      = 4'h8;
  localparam logic [3:0] REG_COUNT     = 4'hc;
  localparam int         CTRL_DYN_EN   = 0;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam int         HIST_DEPTH_DEF = 16;

  typedef enum logic [1:0]
  {
    BRU_IDLE = 2'b00,
    BRU_WAIT = 2'b01
  } bru_state_t;

  typedef struct packed
  {
    logic        is_branch;
    logic        is_cond;
    logic        link_en;
    logic [4:0]  opts;
    logic [4:0]  cbit;
    logic        disp_neg;
    logic [31:0] target;
    logic [31:0] seq_addr;
  } bru_dec_t;

endpackage : bru_pkg

// File: rtl/bru_decode.sv
// Branch decoder and target generator, purely combinational.
// Assumes the instruction, its address and the current link and count
// register values are stable in the cycle they are presented.
`timescale 1ns/1ps

module bru_decode
  import bru_pkg::*;
(
  input  wire logic [31:0] instr,
  input  wire logic [31:0] instr_addr,
  input  wire logic [31:0] link_register,
  input  wire logic [31:0] count_register,
  output bru_dec_t         dec
);

  logic [5:0]  opc;
  logic [9:0]  xo;
  logic [31:0] udisp_ext;
  logic [31:0] cdisp_ext;

  // ----------------------------------------------------------------
  // Displacements
  // ----------------------------------------------------------------
  assign opc       = instr[OPC_MSB:OPC_LSB];
  assign xo        = instr[XO_MSB:XO_LSB];
  assign udisp_ext = {{6{instr[UDISP_MSB]}}, instr[UDISP_MSB:UDISP_LSB], 2'b00};
  assign cdisp_ext = {{16{instr[CDISP_MSB]}}, instr[CDISP_MSB:CDISP_LSB], 2'b00};

  // Target built at decode, even before the condition is known
  always_comb
  begin
    dec           = '0;
    dec.link_en   = instr[LINK_EN_POS];
    dec.opts      = instr[OPTS_MSB:OPTS_LSB];
    dec.cbit      = instr[CBIT_MSB:CBIT_LSB];
    dec.seq_addr  = instr_addr + INSTR_STEP;
    unique case (opc)
      OPC_UNCOND:
      begin
        dec.is_branch = 1'b1;
        dec.opts      = OPTS_ALWAYS;
        dec.target    = instr[ABS_SEL_POS] ? udisp_ext
                                           : instr_addr + udisp_ext;
      end
      OPC_COND:
      begin
        dec.is_branch = 1'b1;
        dec.is_cond   = 1'b1;
        dec.disp_neg  = instr[CDISP_MSB];
        dec.target    = instr[ABS_SEL_POS] ? cdisp_ext
                                           : instr_addr + cdisp_ext;
      end
      OPC_EXT:
      begin
        dec.is_branch = (xo == XO_TO_LINK) || (xo == XO_TO_COUNT);
        dec.is_cond   = dec.is_branch;
        dec.target    = (xo == XO_TO_LINK) ? {link_register[31:2], 2'b00}
                                           : {count_register[31:2], 2'b00};
      end
      default:
      begin
        dec.is_branch = 1'b0;
      end
    endcase
  end

endmodule : bru_decode

// File: rtl/bru_unit.sv
// Branch execution unit: resolves or predicts branches, steers fetch,
// keeps the link and count registers and a small taken-history table.
// Assumes fetch presents one branch at a time while branch_ready is
// high and follows every redirect pulse; cr_busy marks condition bits
// that an in-flight instruction may still write.
//
// Operation
// - Unconditional displacement: 24-bit field with two zero bits appended.
// - Relative unconditional targets add to the branch's own address.
// - Absolute unconditional forms use the extended displacement as target.
// - Conditional displacement: 14-bit field with two zero bits appended.
// - Options field picks the test, bit index picks the condition bit.
// - To-link forms branch to link register with low two bits cleared.
// - To-count forms branch to count register with low two bits cleared.
// - Linking forms write the following instruction's address to link register.
// - Condition true redirects to target, otherwise fetch continues sequentially.
// - Check in-flight writers of tested bit; resolve at once if none.
// - With a pending writer the branch stays unresolved until it completes; a failing count test still resolves it at once.
// - Unresolved branches use history prediction, reversible by hint bit.
// - After predicting, fetch follows the predicted path.
// - On misprediction flush speculative work and refetch the correct path.
// - On correct prediction continue without flush.
// - Immediate targets are computed before the condition resolves.
// - Options bit 0 clear tests condition bit against options bit 1.
// - Options bit 2 clear decrements count and tests it per bit 3.
// - Instruction bit 30 selects absolute, bit 31 enables link update.
// - Hint clear follows sign default; set reverses, except branch-always.
`timescale 1ns/1ps

module bru_unit
  import bru_pkg::*;
#(
  parameter int HIST_DEPTH = HIST_DEPTH_DEF
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              br_valid,
  input  wire logic [31:0]       br_instr,
  input  wire logic [31:0]       br_addr,
  input  wire logic [31:0]       condition_register,
  input  wire logic [31:0]       cr_busy,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   branch_ready,
  output logic                   redirect_valid,
  output logic [31:0]            redirect_addr,
  output logic                   flush,
  output logic                   confirm,
  output logic [31:0]            link_register,
  output logic [31:0]            count_register
);

  localparam int IDX_W = $clog2(HIST_DEPTH);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (HIST_DEPTH < 2 || (1 << IDX_W) != HIST_DEPTH)
  begin : g_bad_depth
    $error("HIST_DEPTH must be a power of two, at least 2");
  end

  bru_state_t       state;
  bru_state_t       next_state;
  bru_dec_t         dec;
  bru_dec_t         saved;
  bru_dec_t         next_saved;
  logic             saved_cnt_ok;
  logic             next_saved_cnt_ok;
  logic             saved_pred;
  logic             next_saved_pred;
  logic [IDX_W-1:0] saved_idx;
  logic [IDX_W-1:0] next_saved_idx;
  logic             next_branch_ready;
  logic             next_redirect_valid;
  logic [31:0]      next_redirect_addr;
  logic             next_flush;
  logic             next_confirm;
  logic [31:0]      next_link_register;
  logic [31:0]      next_count_register;
  logic [31:0]      ctrl;
  logic [31:0]      next_ctrl;
  logic             last_mispredict;
  logic             next_last_mispredict;
  logic [31:0]      next_reg_rdata;
  logic [31:0]      cnt_dec;
  logic             cnt_ok;
  logic             cr_ok;
  logic             cr_pending;
  logic             always_take;
  logic             base_pred;
  logic             pred;
  logic             wait_cr_ok;
  logic             actual;
  logic [IDX_W-1:0] dec_idx;
  logic             hist_we;
  logic [IDX_W-1:0] hist_idx;
  logic             hist_taken;
  logic [HIST_DEPTH-1:0] hist_valid;
  logic [HIST_DEPTH-1:0] hist_bit;

  // ----------------------------------------------------------------
  // Decode and target generation
  // ----------------------------------------------------------------
  bru_decode u_decode
  (
    .instr          (br_instr),
    .instr_addr     (br_addr),
    .link_register  (link_register),
    .count_register (count_register),
    .dec            (dec)
  );

  // Condition evaluation of the branch being decoded and of the waiting branch
  always_comb
  begin
    cnt_dec     = count_register - 32'h0000_0001;
    cnt_ok      = dec.opts[OPT_CNT_SKIP]
                  | ((cnt_dec == 32'h0000_0000) == dec.opts[OPT_CNT_ZERO]);
    cr_ok       = dec.opts[OPT_CR_SKIP]
                  | (condition_register[~dec.cbit] == dec.opts[OPT_CR_VALUE]);
    // Bit index 0 is the most significant condition bit, hence the inversion
    cr_pending  = !dec.opts[OPT_CR_SKIP] && cr_busy[~dec.cbit];
    always_take = dec.opts[OPT_CR_SKIP] & dec.opts[OPT_CNT_SKIP];
    dec_idx     = br_addr[2 +: IDX_W];
    // With dynamic prediction enabled, history wins once an entry has seen an outcome; sign rule otherwise
    base_pred   = always_take ? 1'b1
                : (ctrl[CTRL_DYN_EN] && hist_valid[dec_idx]) ? hist_bit[dec_idx]
                : dec.disp_neg;
    pred        = base_pred ^ (dec.opts[OPT_HINT] & ~always_take);
    wait_cr_ok  = condition_register[~saved.cbit] == saved.opts[OPT_CR_VALUE];
    actual      = saved_cnt_ok & wait_cr_ok;
  end

  // ----------------------------------------------------------------
  // Sequencing, redirect and register updates
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state           = state;
    next_saved           = saved;
    next_saved_cnt_ok    = saved_cnt_ok;
    next_saved_pred      = saved_pred;
    next_saved_idx       = saved_idx;
    next_redirect_valid  = 1'b0;
    next_redirect_addr   = redirect_addr;
    next_flush           = 1'b0;
    next_confirm         = 1'b0;
    next_link_register   = link_register;
    next_count_register  = count_register;
    next_ctrl            = ctrl;
    next_last_mispredict = last_mispredict;
    hist_we              = 1'b0;
    hist_idx             = dec_idx;
    hist_taken           = 1'b0;
    // Software writes first; a branch in the same cycle overrides the link and count writes
    if (reg_wr && reg_addr == REG_CTRL)
    begin
      next_ctrl = {31'h0000_0000, reg_wdata[CTRL_DYN_EN]};
    end
    if (reg_wr && reg_addr == REG_LINK)
    begin
      next_link_register = reg_wdata;
    end
    if (reg_wr && reg_addr == REG_COUNT)
    begin
      next_count_register = reg_wdata;
    end
    unique case (state)
      BRU_IDLE:
      begin
        if (br_valid && dec.is_branch)
        begin
          if (dec.link_en)
          begin
            next_link_register = dec.seq_addr;
          end
          if (!dec.opts[OPT_CNT_SKIP])
          begin
            next_count_register = cnt_dec;
          end
          next_redirect_valid = 1'b1;
          if (!cnt_ok || !cr_pending)
          begin
            // Count test failing settles the branch whatever the bit does
            next_redirect_addr = (cnt_ok && cr_ok) ? dec.target : dec.seq_addr;
            hist_we            = dec.is_cond;
            hist_taken         = cnt_ok && cr_ok;
          end
          else
          begin
            next_redirect_addr = pred ? dec.target : dec.seq_addr;
            next_saved         = dec;
            next_saved_cnt_ok  = cnt_ok;
            next_saved_pred    = pred;
            next_saved_idx     = dec_idx;
            next_state         = BRU_WAIT;
          end
        end
      end
      BRU_WAIT:
      begin
        if (!cr_busy[~saved.cbit])
        begin
          next_state           = BRU_IDLE;
          hist_we              = 1'b1;
          hist_idx             = saved_idx;
          hist_taken           = actual;
          next_last_mispredict = actual != saved_pred;
          if (actual != saved_pred)
          begin
            next_flush          = 1'b1;
            next_redirect_valid = 1'b1;
            next_redirect_addr  = actual ? saved.target : saved.seq_addr;
          end
          else
          begin
            next_confirm = 1'b1;
          end
        end
      end
      default:
      begin
        next_state = BRU_IDLE;
      end
    endcase
    next_branch_ready = next_state == BRU_IDLE;
  end

  // Register read port, data one cycle after the strobe
  always_comb
  begin
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CTRL:   next_reg_rdata = ctrl;
        REG_STATUS: next_reg_rdata = {30'h0000_0000, last_mispredict, state == BRU_WAIT};
        REG_LINK:   next_reg_rdata = link_register;
        REG_COUNT:  next_reg_rdata = count_register;
        default:    next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state           <= BRU_IDLE;
      saved           <= '0;
      saved_cnt_ok    <= 1'b0;
      saved_pred      <= 1'b0;
      saved_idx       <= '0;
      branch_ready    <= 1'b1;
      redirect_valid  <= 1'b0;
      redirect_addr   <= 32'h0000_0000;
      flush           <= 1'b0;
      confirm         <= 1'b0;
      link_register   <= 32'h0000_0000;
      count_register  <= 32'h0000_0000;
      ctrl            <= CTRL_RESET;
      last_mispredict <= 1'b0;
      reg_rdata       <= 32'h0000_0000;
    end
    else
    begin
      state           <= next_state;
      saved           <= next_saved;
      saved_cnt_ok    <= next_saved_cnt_ok;
      saved_pred      <= next_saved_pred;
      saved_idx       <= next_saved_idx;
      branch_ready    <= next_branch_ready;
      redirect_valid  <= next_redirect_valid;
      redirect_addr   <= next_redirect_addr;
      flush           <= next_flush;
      confirm         <= next_confirm;
      link_register   <= next_link_register;
      count_register  <= next_count_register;
      ctrl            <= next_ctrl;
      last_mispredict <= next_last_mispredict;
      reg_rdata       <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Taken-history table, one valid and one outcome bit per entry
  // ----------------------------------------------------------------
  for (genvar g = 0; g < HIST_DEPTH; g++)
  begin : g_hist
    logic next_valid;
    logic next_bit;

    always_comb
    begin
      next_valid = hist_valid[g];
      next_bit   = hist_bit[g];
      if (hist_we && hist_idx == IDX_W'(g))
      begin
        next_valid = 1'b1;
        next_bit   = hist_taken;
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        hist_valid[g] <= 1'b0;
        hist_bit[g]   <= 1'b0;
      end
      else
      begin
        hist_valid[g] <= next_valid;
        hist_bit[g]   <= next_bit;
      end
    end
  end

endmodule : bru_unit

// File: testbench/bru_unit_monitor.sv
// Port-level checker for the branch unit, bound into bru_unit.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps

module bru_unit_monitor
  import bru_pkg::*;
#(
  parameter int HIST_DEPTH = HIST_DEPTH_DEF
)
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              br_valid,
  input wire logic [31:0]       br_instr,
  input wire logic [31:0]       br_addr,
  input wire logic [31:0]       condition_register,
  input wire logic [31:0]       cr_busy,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              branch_ready,
  input wire logic              redirect_valid,
  input wire logic [31:0]       redirect_addr,
  input wire logic              flush,
  input wire logic              confirm,
  input wire logic [31:0]       link_register,
  input wire logic [31:0]       count_register
);
  logic        uncond;
  logic        is_ext;
  logic        always_ext;
  logic        take;
  logic [31:0] li_ext;
  logic [31:0] rel_tgt;
  logic [31:0] seq_addr;
  logic [31:0] cnt_dec;

  // ----
  // Slot decode, only what the properties need
  // ----
  assign uncond     = br_instr[OPC_MSB:OPC_LSB] == OPC_UNCOND;
  assign is_ext     = br_instr[OPC_MSB:OPC_LSB] == OPC_EXT &&
                      (br_instr[XO_MSB:XO_LSB] == XO_TO_LINK || br_instr[XO_MSB:XO_LSB] == XO_TO_COUNT);
  assign always_ext = is_ext && br_instr[25] && br_instr[23];  // No test, so resolved at once
  assign take       = br_valid && branch_ready && (uncond || is_ext || br_instr[OPC_MSB:OPC_LSB] == OPC_COND);
  assign li_ext     = {{6{br_instr[25]}}, br_instr[UDISP_MSB:UDISP_LSB], 2'b00};
  assign rel_tgt    = br_addr + li_ext;
  assign seq_addr   = br_addr + INSTR_STEP;
  assign cnt_dec    = count_register - 32'h0000_0001;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----
  // Properties
  // ----
  AST_TAKE_REDIR: assert property (take |=> redirect_valid)
    else $error("branch taken without redirect");
  AST_REL_TGT: assert property (take && uncond && !br_instr[1] |=> redirect_addr == $past(rel_tgt))
    else $error("relative target wrong");
  AST_ABS_TGT: assert property (take && uncond && br_instr[1] |=> redirect_addr == $past(li_ext))
    else $error("absolute target wrong");
  AST_LR_TGT: assert property (take && always_ext && br_instr[XO_MSB:XO_LSB] == XO_TO_LINK |=>
    redirect_addr == ($past(link_register) & 32'hffff_fffc)) else $error("to-link target wrong");
  AST_CTR_TGT: assert property (take && always_ext && br_instr[XO_MSB:XO_LSB] == XO_TO_COUNT |=>
    redirect_addr == ($past(count_register) & 32'hffff_fffc)) else $error("to-count target wrong");
  AST_LINK_WR: assert property (take && br_instr[LINK_EN_POS] |=> link_register == $past(seq_addr))
    else $error("link value wrong");
  AST_CNT_DEC: assert property (take && !uncond && !br_instr[23] |=> count_register == $past(cnt_dec))
    else $error("count not decremented");
  AST_RES_WAIT: assert property ((flush || confirm) |-> !$past(branch_ready))
    else $error("resolution without a pending branch");
  AST_FLUSH_REDIR: assert property (flush |-> redirect_valid && !confirm)
    else $error("flush without refetch");
  AST_CONFIRM: assert property (confirm |-> !redirect_valid && !flush)
    else $error("confirm disturbed fetch");
endmodule : bru_unit_monitor

bind bru_unit bru_unit_monitor #(.HIST_DEPTH(HIST_DEPTH)) u_bru_unit_monitor (.sys_clk, .rst_n, .br_valid,
  .br_instr, .br_addr, .condition_register, .cr_busy, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .branch_ready, .redirect_valid, .redirect_addr, .flush, .confirm, .link_register, .count_register);

// File: testbench/bru_pipe_model.sv
// Model of the execution pipelines: condition bits and their busy marks.
// Assumes the bench sets the final bits and starts a pending writer.
`timescale 1ns/1ps

module bru_pipe_model
#(
  parameter int HOLD = 4
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] cr_val,
  input  wire logic        hold_go,
  input  wire logic [4:0]  hold_idx,
  output logic [31:0]      condition_register,
  output logic [31:0]      cr_busy
);
  logic [3:0] left;
  logic [4:0] idx;
  logic       tog;

  // Pending writer countdown; the toggle spoils the bit while unwritten
  always_ff @(posedge sys_clk)
  begin
    tog <= rst_n & ~tog;  // Cleared in reset, otherwise it would never leave unknown
    if (!rst_n)
    begin
      left <= 4'h0;
      idx  <= 5'h0;
    end
    else if (hold_go)
    begin
      left <= 4'(HOLD);
      idx  <= hold_idx;
    end
    else if (left != 4'h0)
      left <= left - 4'h1;
  end

  // Busy bit is set only while the writer is still in flight
  always_comb
  begin
    cr_busy            = 32'h0000_0000;
    condition_register = cr_val;
    if (left != 4'h0)
    begin
      cr_busy[31 - idx]            = 1'b1;
      condition_register[31 - idx] = tog;
    end
  end
endmodule : bru_pipe_model

// File: testbench/tb.sv
// Self-checking bench for the branch unit and its pipeline model.
// Assumes the package constants and the hand-over timing of the unit.
`timescale 1ns/1ps

`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); \
    end \
  end

module tb;
  import bru_pkg::*;
  logic              sys_clk   = 0;
  logic              rst_n     = 0;
  logic              br_valid  = 0;
  logic              reg_wr    = 0;
  logic              reg_rd    = 0;
  logic              hold_go   = 0;
  logic              rd_d      = 0;
  logic [31:0]       br_instr  = 0;
  logic [31:0]       br_addr   = 0;
  logic [31:0]       cr_val    = 0;
  logic [31:0]       reg_wdata = 0;
  logic [REG_AW-1:0] reg_addr  = 0;
  logic [4:0]        hold_idx  = 0;
  logic [31:0]       condition_register, cr_busy, reg_rdata, redirect_addr, link_register, count_register;
  logic              branch_ready, redirect_valid, flush, confirm;
  logic [34:0]       nq[$];
  logic [31:0]       rq[$];
  logic [34:0]       note;
  logic [31:0]       exp_rd, a, t, crv, cv, lv, ctr;
  logic [23:0]       li;
  logic [13:0]       bd;
  logic [4:0]        bo, bi;
  logic              tk, p;
  logic [4:0]        bos[9] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0a, 5'h0c, 5'h10, 5'h12, 5'h14};
  int                error_cnt = 0;
  int                cmp_count = 0;
  int                seed      = 95;
  int                n;

  always #20 sys_clk = ~sys_clk;

  bru_unit u_bru_unit (.sys_clk, .rst_n, .br_valid, .br_instr, .br_addr, .condition_register, .cr_busy,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .branch_ready, .redirect_valid, .redirect_addr,
    .flush, .confirm, .link_register, .count_register);
  bru_pipe_model u_bru_pipe_model (.sys_clk, .rst_n, .cr_val, .hold_go, .hold_idx, .condition_register,
    .cr_busy);

  function automatic logic [31:0] sx16(logic [13:0] d);
    return {{16{d[13]}}, d, 2'b00};
  endfunction : sx16

  // ----
  // Drivers: one slot per cycle, every strobe set each time
  // ----
  task automatic bus(logic w, logic r, logic g, logic [3:0] ad, logic [31:0] d);
    if (r)
      rq.push_back(d);
    br_valid  <= 1'b0;
    reg_wr    <= w;
    reg_rd    <= r;
    hold_go   <= g;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask : bus

  task automatic br(logic [31:0] i, logic [31:0] ad, logic [31:0] e);
    nq.push_back({3'b100, e});
    br_valid <= 1'b1;
    br_instr <= i;
    br_addr  <= ad;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b0;
    hold_go  <= 1'b0;
    @(posedge sys_clk);
  endtask : br

  task automatic results;
    $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Oldest note against each pulse; a stray pulse meets an all-ones note
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd & rst_n;
    if (rst_n && (redirect_valid || flush || confirm))
    begin
      note = nq.size() ? nq.pop_front() : '1;
      `CHK({redirect_valid, flush, confirm, redirect_valid ? redirect_addr : 32'h0}, note)
    end
    if (rd_d)
    begin
      exp_rd = rq.size() ? rq.pop_front() : 32'hdead_beef;
      `CHK(reg_rdata, exp_rd)
    end
  end

  // Whole run is about a hundred cycles; this cuts a hang short
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    error_cnt++;
    results();
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(0, 0, 0, 4'h0, 0);
    bus(0, 1, 0, REG_CTRL, CTRL_RESET);
    bus(0, 1, 0, REG_LINK, 0);
    bus(0, 1, 0, 4'h2, 0);
    $display("test reset done");
    // Unconditional forms back to back, the second and the last one link
    for (int k = 0; k < 4; k++)
    begin
      li = 24'($random(seed));
      a  = $random(seed) & 32'hffff_fffc;
      t  = {{6{li[23]}}, li, 2'b00};
      br({OPC_UNCOND, li, k[1], k[0]}, a, k[1] ? t : a + t);
    end
    bus(0, 1, 0, REG_LINK, a + 32'h4);
    $display("test unconditional done");
    // Nine options encodings, hint clear, resolved at once, counts at the zero boundary
    foreach (bos[j])
    begin
      bo  = bos[j];
      cv  = 32'(j % 3);
      ctr = bo[2] ? cv : cv - 32'h1;
      bi  = 5'($random(seed));
      bd  = 14'($random(seed));
      crv = $random(seed);
      a   = $random(seed) & 32'hffff_fffc;
      tk  = (bo[2] | ((ctr == 0) == bo[1])) & (bo[4] | (crv[31 - bi] == bo[3]));
      t   = j[0] ? sx16(bd) : a + sx16(bd);
      cr_val <= crv;
      bus(1, 0, 0, REG_COUNT, cv);
      br({OPC_COND, bo, bi, bd, j[0], j[1]}, a, tk ? t : a + 32'h4);
      bus(0, 1, 0, REG_COUNT, ctr);
    end
    $display("test conditional done");
    // Register targets with dirty low bits; the link read sees the value the to-link branch wrote
    lv = $random(seed) | 32'h3;
    cv = $random(seed) | 32'h3;
    a  = $random(seed) & 32'hffff_fffc;
    bus(1, 0, 0, REG_LINK, lv);
    bus(1, 0, 0, REG_COUNT, cv);
    br({OPC_EXT, OPTS_ALWAYS, 10'h0, XO_TO_LINK, 1'b1}, a, lv & 32'hffff_fffc);
    br({OPC_EXT, OPTS_ALWAYS, 10'h0, XO_TO_COUNT, 1'b0}, a + 32'h4, cv & 32'hffff_fffc);
    bus(0, 1, 0, REG_LINK, a + 32'h4);
    bus(0, 1, 0, REG_COUNT, cv);
    $display("test register targets done");
    // Pending writer: sign and hint pick the path, history kept off
    bus(1, 0, 0, REG_CTRL, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      bd     = 14'($random(seed));
      bd[13] = k[1];
      bi     = 5'($random(seed));
      crv    = $random(seed);
      a      = $random(seed) & 32'hffff_fffc;
      tk     = crv[31 - bi];
      p      = k[1] ^ k[0];
      t      = a + sx16(bd);
      cr_val   <= crv;
      hold_idx <= bi;
      bus(0, 0, 1, 4'h0, 0);
      br({OPC_COND, 4'b0110, k[0], bi, bd, 2'b00}, a, p ? t : a + 32'h4);
      nq.push_back(p == tk ? 35'h1_0000_0000 : {3'b110, tk ? t : a + 32'h4});
      bus(0, 0, 0, 4'h0, 0);
      for (n = 0; n < 20 && branch_ready !== 1'b1; n++)
        bus(0, 0, 0, 4'h0, 0);
      `CHK(n > 1, 1'b1)
      bus(0, 1, 0, REG_STATUS, {30'h0000_0000, p != tk, 1'b0});
    end
    bus(1, 0, 0, REG_CTRL, CTRL_RESET);
    // History on: a not-taken outcome here outweighs the backward displacement
    bd       = 14'h2000;
    cr_val   <= 32'h0000_0000;
    hold_idx <= 5'h00;
    br({OPC_COND, 5'h0c, 5'h00, bd, 2'b00}, a, a + 32'h4);
    bus(0, 0, 1, 4'h0, 0);
    br({OPC_COND, 5'h0c, 5'h00, bd, 2'b00}, a, a + 32'h4);
    nq.push_back(35'h1_0000_0000);
    repeat (7) bus(0, 0, 0, 4'h0, 0);
    `CHK(nq.size(), 0)
    $display("test prediction done");
    results();
  end
endmodule : tb
